// [common/csf_pkg.sv]
// csf_pkg: constants for the cpu status flag block
// assumes apb with 32-bit data; one register per aligned word
package csf_pkg;
    localparam int DATA_W = 8;
    localparam int APB_AW = 8;
    // register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_PCL = 8'h04;
    localparam logic [7:0] ADDR_LOOKUP_PTR_LOW = 8'h08;
    localparam logic [7:0] ADDR_LOOKUP_PTR_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_LOOKUP_RESULT_HIGH = 8'h10;
    localparam logic [7:0] ADDR_ACC = 8'h14;
    localparam logic [7:0] ADDR_PC = 8'h18;
    localparam logic [7:0] ADDR_SECT = 8'h1C;
    // status bit positions
    localparam int BIT_C = 0;
    localparam int BIT_AC = 1;
    localparam int BIT_Z = 2;
    localparam int BIT_OV = 3;
    localparam int BIT_PDF = 4;
    localparam int BIT_TO = 5;
    localparam int BIT_CZ = 6;
    localparam int BIT_SC = 7;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] STATUS_WMASK = 8'hCF;
    localparam int PC_W = 13;
    localparam int XADDR_W = 10;
    localparam logic [2:0] ERR_NONE = 3'h0;
    typedef enum logic [3:0] {
        CSF_OP_NOP = 4'h0,
        CSF_OP_ADD = 4'h1,
        CSF_OP_ADC = 4'h2,
        CSF_OP_SUB = 4'h3,
        CSF_OP_SBC = 4'h4,
        CSF_OP_AND = 4'h5,
        CSF_OP_OR = 4'h6,
        CSF_OP_XOR = 4'h7,
        CSF_OP_RLC = 4'h8,
        CSF_OP_RRC = 4'h9,
        CSF_OP_MOV = 4'hA,
        CSF_OP_INC = 4'hB,
        CSF_OP_DEC = 4'hC
    } csf_op_e;
    typedef enum logic [1:0] {
        CSF_ST_RUN = 2'b00,
        CSF_ST_DUMMY = 2'b01
    } csf_state_e;
endpackage : csf_pkg

// [verilog/csf_alu.sv]
// csf_alu: combinational 8-bit alu producing result and arithmetic flags
// assumes operands and carry-in are stable for the whole write-back cycle
`timescale 1ns/1ps
module csf_alu
    import csf_pkg::*;
(
    input wire csf_pkg::csf_op_e op,
    input wire logic [7:0] opA,
    input wire logic [7:0] opB,
    input wire logic carryIn,
    output logic [7:0] result,
    output logic flagC,
    output logic flagAc,
    output logic flagZ,
    output logic flagOv,
    output logic flagsArith
);
    logic [8:0] full;
    logic [4:0] nib;
    logic [7:0] low7;
    logic c7;
    logic [7:0] bInv;
    logic cin;
    always_comb
    begin
        bInv = ~opB;
        cin = 1'b0;
        result = opA;
        full = 9'h000;
        nib = 5'h00;
        low7 = 8'h00;
        c7 = 1'b0;
        flagC = carryIn;
        flagAc = 1'b0;
        flagOv = 1'b0;
        flagsArith = 1'b0;
        case (op)
            CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC:
            begin
                // subtraction is a + ~b + 1, so carry out means no borrow
                if (op == CSF_OP_ADC)
                    cin = carryIn;
                else if (op == CSF_OP_SUB)
                    cin = 1'b1;
                else if (op == CSF_OP_SBC)
                    cin = carryIn;
                if (op == CSF_OP_SUB || op == CSF_OP_SBC)
                begin
                    full = {1'b0, opA} + {1'b0, bInv} + {8'h00, cin};
                    nib = {1'b0, opA[3:0]} + {1'b0, bInv[3:0]} + {4'h0, cin};
                    low7 = {1'b0, opA[6:0]} + {1'b0, bInv[6:0]} + {7'h00, cin};
                end
                else
                begin
                    full = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
                    nib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
                    low7 = {1'b0, opA[6:0]} + {1'b0, opB[6:0]} + {7'h00, cin};
                end
                c7 = low7[7];
                result = full[7:0];
                flagC = full[8];
                flagAc = nib[4];
                flagOv = c7 ^ full[8];
                flagsArith = 1'b1;
            end
            CSF_OP_AND: result = opA & opB;
            CSF_OP_OR: result = opA | opB;
            CSF_OP_XOR: result = opA ^ opB;
            CSF_OP_INC: result = opA + 8'h01;
            CSF_OP_DEC: result = opA - 8'h01;
            CSF_OP_RLC:
            begin
                result = {opA[6:0], carryIn};
                flagC = opA[7];
            end
            CSF_OP_RRC:
            begin
                result = {carryIn, opA[7:1]};
                flagC = opA[0];
            end
            CSF_OP_MOV: result = opB;
            default: result = opA;
        endcase
        flagZ = (result == 8'h00);
    end
endmodule : csf_alu

// [verilog/csf_status_core.sv]
// csf_status_core: status flags, accumulator, pc low jump, table pointers, sector addressing
// assumes a sequencer drives one-cycle instruction strobes on clk_sys and an apb master
`timescale 1ns/1ps
// How it works
// - writing pc low byte jumps within the current page, high bits kept
// - such a jump inserts one dummy cycle before execution resumes
// - table read puts word high byte in result-high, low byte to destination
// - time-out and halted flags are read-only; other status bits writable
// - time-out clears on power-up, kick and stop; sets on watchdog expiry
// - halted clears on power-up or kick; sets on stop
// - carry flag is add carry, subtract no-borrow, and rotate carry
// - half carry is nibble carry, or nibble no-borrow in subtraction
// - zero flag set when result is zero, for every instruction but nop and mov (which leave status unchanged)
// - overflow flag is carry into msb xor carry out of msb
// - signed-less flag is new overflow xor result msb
// - subtract group copies new zero flag into chain-zero
// - subtract-with-borrow group ANDs chain-zero with new zero
// - all other instructions leave chain-zero unchanged
// - status is never saved automatically on interrupt or call
// - no register-to-register moves; data passes through the accumulator
// - extended address upper part selects sector, low byte the location
// - extended addresses carry ten valid bits
module csf_status_core
    import csf_pkg::*;
#(
    parameter int PCW = csf_pkg::PC_W
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instrValid,
    input wire csf_pkg::csf_op_e instrOp,
    input wire logic [7:0] instrOperand,
    input wire logic instrToAcc,
    input wire logic watchdogKick,
    input wire logic stopInstr,
    input wire logic watchdogTimeout,
    input wire logic tableReadDone,
    input wire logic [15:0] tableWord,
    input wire logic [1:0] ptrStep,
    input wire logic [csf_pkg::XADDR_W-1:0] extAddr,
    output logic [7:0] destData,
    output logic destWrite,
    output logic [PCW-1:0] progCtr,
    output logic jumpTaken,
    output logic execStall,
    output logic [PCW-1:0] lookupAddr,
    output logic [1:0] extSector,
    output logic [7:0] extOffset
);
    import csf_pkg::*;

    if (PCW < 9 || PCW > 16)
    begin : gen_pcw_check
        $error("csf_status_core: PCW must lie in 9..16");
    end

    logic [7:0] status_reg;
    logic [7:0] acc_reg;
    logic [7:0] lookup_ptr_low_reg;
    logic [7:0] lookup_ptr_high_reg;
    logic [7:0] lookup_result_high_reg;
    logic [PCW-1:0] pc_reg;
    logic [31:0] prdata_reg;
    logic [7:0] destData_reg;
    logic destWrite_reg;
    csf_state_e state_reg;
    csf_state_e state_next;

    logic [7:0] aluResult;
    logic aluC;
    logic aluAc;
    logic aluZ;
    logic aluOv;
    logic aluArith;
    logic apbAccess;
    logic apbWr;
    logic addrHit;
    logic [7:0] wByte;
    logic execOk;
    logic pclWrite;

    assign apbAccess = psel & penable;
    assign apbWr = apbAccess & pwrite & pstrb[0];
    assign wByte = pwdata[7:0];
    assign pready = 1'b1;
    assign addrHit = (paddr == ADDR_STATUS) || (paddr == ADDR_PCL) || (paddr == ADDR_LOOKUP_PTR_LOW)
        || (paddr == ADDR_LOOKUP_PTR_HIGH) || (paddr == ADDR_LOOKUP_RESULT_HIGH) || (paddr == ADDR_ACC)
        || (paddr == ADDR_PC) || (paddr == ADDR_SECT);
    assign pslverr = apbAccess & ~addrHit;
    assign prdata = prdata_reg;
    assign pclWrite = apbWr && (paddr == ADDR_PCL);
    assign execOk = instrValid && (state_reg == CSF_ST_RUN);
    assign execStall = (state_reg == CSF_ST_DUMMY);
    assign jumpTaken = pclWrite;
    assign destData = destData_reg;
    assign destWrite = destWrite_reg;
    assign progCtr = pc_reg;
    assign lookupAddr = PCW'({lookup_ptr_high_reg, lookup_ptr_low_reg});
    assign extSector = extAddr[XADDR_W-1:8];
    assign extOffset = extAddr[7:0];

    // operands come only from the accumulator and one memory byte
    csf_alu u_alu (
        .op(instrOp),
        .opA(acc_reg),
        .opB(instrOperand),
        .carryIn(status_reg[BIT_C]),
        .result(aluResult),
        .flagC(aluC),
        .flagAc(aluAc),
        .flagZ(aluZ),
        .flagOv(aluOv),
        .flagsArith(aluArith)
    );

    // jump dummy cycle sequencing
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            CSF_ST_RUN: if (pclWrite) state_next = CSF_ST_DUMMY;
            CSF_ST_DUMMY: state_next = CSF_ST_RUN;
            default: state_next = CSF_ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            state_reg <= CSF_ST_RUN;
        else
            state_reg <= state_next;
    end

    // program counter; a pcl write swaps only the low byte
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            pc_reg <= '0;
        else if (pclWrite)
            pc_reg <= {pc_reg[PCW-1:8], wByte};
        else if (apbWr && paddr == ADDR_PC)
            pc_reg <= pwdata[PCW-1:0];
        else if (execOk)
            pc_reg <= pc_reg + PCW'(1);
    end

    // accumulator holds alu results only when instrToAcc is set; moves between registers go through it
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            acc_reg <= 8'h00;
        else if (apbWr && paddr == ADDR_ACC)
            acc_reg <= wByte;
        else if (execOk && instrOp != CSF_OP_NOP && instrToAcc)
            acc_reg <= aluResult;
    end

    // results bound for memory leave through the destination port
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            destData_reg <= 8'h00;
            destWrite_reg <= 1'b0;
        end
        else if (tableReadDone)
        begin
            destData_reg <= tableWord[7:0];
            destWrite_reg <= 1'b1;
        end
        else
        begin
            destData_reg <= aluResult;
            destWrite_reg <= execOk && instrOp != CSF_OP_NOP && !instrToAcc;
        end
    end

    // table pointers: software loads them, instructions may step the low one
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            lookup_ptr_low_reg <= 8'h00;
            lookup_ptr_high_reg <= 8'h00;
        end
        else
        begin
            if (apbWr && paddr == ADDR_LOOKUP_PTR_LOW)
                lookup_ptr_low_reg <= wByte;
            else if (ptrStep == 2'b01)
                lookup_ptr_low_reg <= lookup_ptr_low_reg + 8'h01;
            else if (ptrStep == 2'b10)
                lookup_ptr_low_reg <= lookup_ptr_low_reg - 8'h01;
            if (apbWr && paddr == ADDR_LOOKUP_PTR_HIGH)
                lookup_ptr_high_reg <= wByte;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            lookup_result_high_reg <= 8'h00;
        else if (tableReadDone)
            lookup_result_high_reg <= tableWord[15:8];
    end

    // status flags; hardware events beat a simultaneous software write
    // status is not stacked on call or interrupt: software saves it
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            status_reg <= STATUS_RST;
        else
        begin
            if (apbWr && paddr == ADDR_STATUS)
                status_reg <= (status_reg & ~STATUS_WMASK) | (wByte & STATUS_WMASK);
            if (execOk && instrOp != CSF_OP_NOP && instrOp != CSF_OP_MOV)
            begin
                status_reg[BIT_Z] <= aluZ;
                status_reg[BIT_SC] <= (aluArith ? aluOv : status_reg[BIT_OV]) ^ aluResult[7];
                if (aluArith || instrOp == CSF_OP_RLC || instrOp == CSF_OP_RRC)
                    status_reg[BIT_C] <= aluC;
                if (aluArith)
                begin
                    status_reg[BIT_AC] <= aluAc;
                    status_reg[BIT_OV] <= aluOv;
                end
                if (instrOp == CSF_OP_SUB)
                    status_reg[BIT_CZ] <= aluZ;
                else if (instrOp == CSF_OP_SBC)
                    status_reg[BIT_CZ] <= status_reg[BIT_CZ] & aluZ;
            end
            // other ops leave chain-zero alone
            // kick first, so a stop or time-out in the same cycle still sets its flag
            if (watchdogKick)
            begin
                status_reg[BIT_PDF] <= 1'b0;
                status_reg[BIT_TO] <= 1'b0;
            end
            if (stopInstr)
            begin
                status_reg[BIT_PDF] <= 1'b1;
                status_reg[BIT_TO] <= 1'b0;
            end
            if (watchdogTimeout)
                status_reg[BIT_TO] <= 1'b1;
        end
    end

    // apb read data registered in the setup phase (psel high, penable low), ready for the access phase
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            prdata_reg <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                ADDR_STATUS: prdata_reg <= {24'h000000, status_reg};
                ADDR_PCL: prdata_reg <= {24'h000000, pc_reg[7:0]};
                ADDR_LOOKUP_PTR_LOW: prdata_reg <= {24'h000000, lookup_ptr_low_reg};
                ADDR_LOOKUP_PTR_HIGH: prdata_reg <= {24'h000000, lookup_ptr_high_reg};
                ADDR_LOOKUP_RESULT_HIGH: prdata_reg <= {24'h000000, lookup_result_high_reg};
                ADDR_ACC: prdata_reg <= {24'h000000, acc_reg};
                ADDR_PC: prdata_reg <= 32'(pc_reg);
                ADDR_SECT: prdata_reg <= 32'(extAddr);
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // reference sums for the assertions, built apart from the alu
    logic [8:0] addSum;
    logic [4:0] addNib;
    assign addSum = {1'b0, acc_reg} + {1'b0, instrOperand};
    assign addNib = {1'b0, acc_reg[3:0]} + {1'b0, instrOperand[3:0]};

    sequence seqPclWrite;
        pclWrite;
    endsequence

    chk_pcl_jump_page: assert property (@(posedge clk_sys) disable iff (reset)
        seqPclWrite |=> (pc_reg[7:0] == $past(wByte)) && (pc_reg[PCW-1:8] == $past(pc_reg[PCW-1:8])))
        else $error("pcl jump left the page");
    chk_dummy_cycle: assert property (@(posedge clk_sys) disable iff (reset)
        seqPclWrite |=> execStall ##1 !execStall)
        else $error("dummy cycle missing");
    chk_table_high: assert property (@(posedge clk_sys) disable iff (reset)
        tableReadDone |=> lookup_result_high_reg == $past(tableWord[15:8]) && destWrite)
        else $error("table high byte wrong");
    chk_ro_flags: assert property (@(posedge clk_sys) disable iff (reset)
        (!watchdogKick && !stopInstr && !watchdogTimeout) |=> $stable(status_reg[5:4]))
        else $error("read-only flag changed");
    chk_timeout_set: assert property (@(posedge clk_sys) disable iff (reset)
        watchdogTimeout |=> status_reg[BIT_TO])
        else $error("time-out flag not set");
    chk_halt_set: assert property (@(posedge clk_sys) disable iff (reset)
        stopInstr |=> status_reg[BIT_PDF])
        else $error("halted flag not set");
    chk_sub_chain: assert property (@(posedge clk_sys) disable iff (reset)
        (execOk && instrOp == CSF_OP_SUB) |=> status_reg[BIT_CZ] == status_reg[BIT_Z])
        else $error("chain zero not copied");
    chk_chain_hold: assert property (@(posedge clk_sys) disable iff (reset)
        (!(execOk && (instrOp == CSF_OP_SUB || instrOp == CSF_OP_SBC)) && !(apbWr && paddr == ADDR_STATUS))
        |=> $stable(status_reg[BIT_CZ]))
        else $error("chain zero moved");
    chk_zero_flag: assert property (@(posedge clk_sys) disable iff (reset)
        (execOk && instrOp == CSF_OP_AND) |=> status_reg[BIT_Z] == ($past(acc_reg & instrOperand) == 8'h00))
        else $error("zero flag wrong");
    chk_sign_less: assert property (@(posedge clk_sys) disable iff (reset)
        (execOk && instrOp == CSF_OP_ADD) |=> status_reg[BIT_SC] == (status_reg[BIT_OV] ^ $past(aluResult[7])))
        else $error("signed-less flag wrong");
    chk_stall_freeze: assert property (@(posedge clk_sys) disable iff (reset)
        (execStall && !apbWr) |=> $stable(pc_reg))
        else $error("instruction ran in the dummy cycle");
    chk_add_carry: assert property (@(posedge clk_sys) disable iff (reset)
        (execOk && instrOp == CSF_OP_ADD) |=> status_reg[BIT_C] == $past(addSum[8]))
        else $error("carry flag wrong after add");
    chk_add_half: assert property (@(posedge clk_sys) disable iff (reset)
        (execOk && instrOp == CSF_OP_ADD) |=> status_reg[BIT_AC] == $past(addNib[4]))
        else $error("half carry flag wrong after add");
    chk_add_overflow: assert property (@(posedge clk_sys) disable iff (reset)
        (execOk && instrOp == CSF_OP_ADD) |=> status_reg[BIT_OV] == $past((acc_reg[7] == instrOperand[7]) && (addSum[7] != acc_reg[7])))
        else $error("overflow flag wrong after add");
    chk_sbc_chain: assert property (@(posedge clk_sys) disable iff (reset)
        (execOk && instrOp == CSF_OP_SBC) |=> status_reg[BIT_CZ] == ($past(status_reg[BIT_CZ]) && status_reg[BIT_Z]))
        else $error("chain zero not accumulated");
    chk_result_flags: assert property (@(posedge clk_sys) disable iff (reset)
        (execOk && instrToAcc && !apbWr && instrOp != CSF_OP_NOP && instrOp != CSF_OP_MOV) |=> status_reg[BIT_Z] == (acc_reg == 8'h00))
        else $error("zero flag not updated with the result");
endmodule : csf_status_core

// [sim/csf_status_core_bench.sv]
// csf_status_core_bench: self-checking bench for the status flag core
// assumes the core answers apb with pready high and takes one instruction per cycle
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin numErrors++; \
    $display("wrong value t=%0t got %h exp %h", $time, (got), (exp)); end end
module csf_status_core_bench
    import csf_pkg::*;
;
    logic clk_sys, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, instrOperand, destData, extOffset;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic instrValid, instrToAcc, watchdogKick, stopInstr, watchdogTimeout, tableReadDone;
    logic destWrite, jumpTaken, execStall;
    csf_op_e instrOp;
    logic [15:0] tableWord;
    logic [1:0] ptrStep, extSector;
    logic [XADDR_W-1:0] extAddr;
    logic [PC_W-1:0] progCtr, lookupAddr;
    int checks = 0;
    int numErrors = 0;
    int jumpCnt = 0;
    int stallCnt = 0;

    csf_status_core #(.PCW(PC_W)) i_csf_status_core (
        .clk_sys(clk_sys), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instrValid(instrValid), .instrOp(instrOp), .instrOperand(instrOperand),
        .instrToAcc(instrToAcc), .watchdogKick(watchdogKick), .stopInstr(stopInstr),
        .watchdogTimeout(watchdogTimeout), .tableReadDone(tableReadDone), .tableWord(tableWord),
        .ptrStep(ptrStep), .extAddr(extAddr), .destData(destData), .destWrite(destWrite),
        .progCtr(progCtr), .jumpTaken(jumpTaken), .execStall(execStall), .lookupAddr(lookupAddr),
        .extSector(extSector), .extOffset(extOffset));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // counting per edge catches a jump or stall that lasts longer than one cycle
    always @(posedge clk_sys)
    begin
        if (jumpTaken === 1'b1)
            jumpCnt <= jumpCnt + 1;
        if (execStall === 1'b1)
            stallCnt <= stallCnt + 1;
    end

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks, numErrors);
        if (numErrors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // starts one edge later so a release and the next request never share a time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 50)
            numErrors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, {24'h000000, v}, d, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h00000000, d, e);
    endtask : rd

    task automatic op(input csf_op_e o, input logic [7:0] v);
        @(posedge clk_sys);
        instrValid <= 1'b1;
        instrOp <= o;
        instrOperand <= v;
        instrToAcc <= 1'b1;
        @(posedge clk_sys);
        instrValid <= 1'b0;
    endtask : op

    // runs one instruction, then compares accumulator and status
    task automatic op_chk(input csf_op_e o, input logic [7:0] v, input logic [7:0] accExp, input logic [7:0] stExp);
        logic [31:0] d;
        op(o, v);
        rd(ADDR_ACC, d);
        `CHK(d[7:0], accExp)
        rd(ADDR_STATUS, d);
        `CHK(d[7:0], stExp)
    endtask : op_chk

    // k = {timeout, stop, kick}
    task automatic evt(input logic [2:0] k);
        @(posedge clk_sys);
        {watchdogTimeout, stopInstr, watchdogKick} <= k;
        @(posedge clk_sys);
        {watchdogTimeout, stopInstr, watchdogKick} <= 3'b000;
    endtask : evt

    task automatic t_reset_values;
        logic [31:0] d;
        logic e;
        logic [7:0] addrs [8] = '{ADDR_STATUS, ADDR_PCL, ADDR_LOOKUP_PTR_LOW, ADDR_LOOKUP_PTR_HIGH, ADDR_LOOKUP_RESULT_HIGH, ADDR_ACC, ADDR_PC,
                                  ADDR_SECT};
        foreach (addrs[i])
        begin
            rd(addrs[i], d);
            `CHK(d, 32'h00000000)
        end
        apb(1'b0, 8'h20, 32'h00000000, d, e);
        `CHK({e, d}, 33'h100000000)
        apb(1'b1, 8'h24, 32'h000000FF, d, e);
        `CHK(e, 1'b1)
    endtask : t_reset_values

    task automatic t_status;
        logic [31:0] d;
        evt(3'b100);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h00000020)
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h00000020)
        evt(3'b010);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h00000010)
        wr(ADDR_STATUS, 8'hFF);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h000000DF)
        evt(3'b001);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h000000CF)
        evt(3'b100);
        evt(3'b001);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h000000CF)
        // all three at once: both flags end set, since a set beats a clear
        evt(3'b111);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h000000FF)
        evt(3'b001);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h000000CF)
    endtask : t_status

    task automatic t_alu;
        logic [31:0] d;
        wr(ADDR_STATUS, 8'h00);
        wr(ADDR_ACC, 8'h88);
        op(CSF_OP_ADD, 8'h88);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h0000008B)
        rd(ADDR_ACC, d);
        `CHK(d, 32'h00000010)
        op(CSF_OP_SUB, 8'h10);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h00000047)
        op(CSF_OP_SBC, 8'h01);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h00000080)
        op(CSF_OP_AND, 8'h00);
        rd(ADDR_STATUS, d);
        `CHK(d[7:0] & 8'h44, 8'h04)
        // chain-zero clear beforehand: a copy of the zero flag would read 1 here
        wr(ADDR_STATUS, 8'h01);
        op(CSF_OP_SBC, 8'h00);
        rd(ADDR_STATUS, d);
        `CHK(d, 32'h00000007)
        wr(ADDR_STATUS, 8'h00);
        wr(ADDR_ACC, 8'h80);
        op(CSF_OP_RLC, 8'h00);
        rd(ADDR_STATUS, d);
        `CHK(d[0], 1'b1)
        op(CSF_OP_RRC, 8'h00);
        rd(ADDR_ACC, d);
        `CHK(d, 32'h00000080)
        rd(ADDR_STATUS, d);
        `CHK(d[0], 1'b0)
        wr(ADDR_STATUS, 8'h01);
        op_chk(CSF_OP_ADC, 8'h7F, 8'h00, 8'h07);
        op_chk(CSF_OP_OR, 8'h5A, 8'h5A, 8'h03);
        op_chk(CSF_OP_XOR, 8'h5A, 8'h00, 8'h07);
        op_chk(CSF_OP_DEC, 8'h00, 8'hFF, 8'h83);
        op_chk(CSF_OP_INC, 8'h00, 8'h00, 8'h07);
        op_chk(CSF_OP_MOV, 8'h33, 8'h33, 8'h07);
    endtask : t_alu

    task automatic t_jump;
        logic [PC_W-1:0] old;
        int j0;
        int s0;
        old = progCtr;
        j0 = jumpCnt;
        s0 = stallCnt;
        wr(ADDR_PCL, 8'hA5);
        // an instruction offered in the dummy cycle must wait one edge
        instrValid <= 1'b1;
        instrOp <= CSF_OP_NOP;
        #1;
        `CHK(progCtr, {old[PC_W-1:8], 8'hA5})
        `CHK(execStall, 1'b1)
        @(posedge clk_sys);
        #1;
        `CHK(progCtr, {old[PC_W-1:8], 8'hA5})
        @(posedge clk_sys);
        instrValid <= 1'b0;
        #1;
        `CHK(progCtr, {old[PC_W-1:8], 8'hA6})
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK(jumpCnt - j0, 1)
        `CHK(stallCnt - s0, 1)
    endtask : t_jump

    task automatic t_table;
        logic [31:0] d;
        wr(ADDR_LOOKUP_PTR_LOW, 8'h10);
        wr(ADDR_LOOKUP_PTR_HIGH, 8'h02);
        @(posedge clk_sys);
        ptrStep <= 2'b01;
        @(posedge clk_sys);
        ptrStep <= 2'b10;
        repeat (2) @(posedge clk_sys);
        ptrStep <= 2'b00;
        #1;
        `CHK(lookupAddr, PC_W'(16'h020F))
        @(posedge clk_sys);
        tableWord <= 16'h3CA5;
        instrToAcc <= 1'b0;
        tableReadDone <= 1'b1;
        @(posedge clk_sys);
        tableReadDone <= 1'b0;
        #1;
        `CHK({destWrite, destData}, 9'h1A5)
        rd(ADDR_LOOKUP_RESULT_HIGH, d);
        `CHK(d, 32'h0000003C)
    endtask : t_table

    task automatic t_ext;
        logic [9:0] v [3] = '{10'h1F0, 10'h3FF, 10'h0A5};
        logic [31:0] d;
        foreach (v[i])
        begin
            @(posedge clk_sys);
            extAddr <= v[i];
            @(posedge clk_sys);
            #1;
            `CHK({extSector, extOffset}, v[i])
        end
        rd(ADDR_SECT, d);
        `CHK(d, 32'h000000A5)
    endtask : t_ext

    initial
    begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = {3'b000, 8'h00, 32'h00000000, 4'hF};
        {instrValid, instrOperand, instrToAcc, tableReadDone, tableWord} = '0;
        {watchdogKick, stopInstr, watchdogTimeout, ptrStep, extAddr} = '0;
        instrOp = CSF_OP_NOP;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset_values();
        t_status();
        t_alu();
        t_jump();
        t_table();
        t_ext();
        tally_and_finish();
    end

    // the whole sequence needs well under a thousand cycles
    initial
    begin
        #50000;
        numErrors++;
        tally_and_finish();
    end
endmodule : csf_status_core_bench
